//--- lpb_pkg.sv
// lpb_pkg: register map, field positions, reset values and word geometry
// of the link boot loader; shared by the receiver, DMA channel, top module and testbench.
// assumes a 32-bit register port with an 8-bit byte address.
`default_nettype none
package lpb_pkg;
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_LIRPTL      = 8'h04;
    localparam logic [7:0]  OFS_IMASK       = 8'h08;
    localparam logic [7:0]  OFS_DMA_INDEX   = 8'h0C;
    localparam logic [7:0]  OFS_DMA_MOD     = 8'h10;
    localparam logic [7:0]  OFS_DMA_COUNT   = 8'h14;
    localparam logic [7:0]  OFS_DMA_CHAIN   = 8'h18;
    localparam logic [7:0]  OFS_DMA_GENERAL = 8'h1C;
    localparam logic [7:0]  OFS_RX_LOW      = 8'h20;
    localparam logic [7:0]  OFS_RX_HIGH     = 8'h24;
    localparam logic [7:0]  OFS_BOOT_STAT   = 8'h28;
    localparam logic [31:0] CTRL_BOOT       = 32'h0020_0011;
    localparam logic [31:0] CTRL_HOLD_ONE   = 32'h0000_0013;
    localparam logic [31:0] CTRL_HOLD_ZERO  = 32'h0000_0200;
    localparam logic [31:0] CTRL_STAT_MASK  = 32'h0C00_0000;
    localparam int          BIT_PORT_EN     = 0;
    localparam int          BIT_DMA_EN      = 1;
    localparam int          BIT_WIDE_WORD   = 4;
    localparam int          BIT_WIDTH_SEL   = 9;
    localparam int          BIT_STAT_LOW    = 26;
    localparam int          BIT_STAT_HIGH   = 27;
    localparam logic [31:0] LIRPTL_BOOT     = 32'h0001_0000;
    localparam int          BIT_LB0_MASK    = 16;
    localparam int          BIT_LB0_LATCH   = 0;
    localparam logic [31:0] IMASK_BOOT      = 32'h0000_4003;
    localparam int          BIT_IMASK_LINK  = 14;
    localparam logic [31:0] DMA_INDEX_RST   = 32'h0004_0000;
    localparam logic [15:0] DMA_MOD_RST     = 16'h0001;
    localparam logic [15:0] DMA_COUNT_RST   = 16'h0100;
    localparam logic [31:0] VECTOR_BASE     = 32'h0004_0000;
    localparam logic [31:0] VECTOR_LB0_OFS  = 32'h0000_0038;
    localparam int          WORD_W          = 48;
    localparam int          NIBBLES         = 12;
    localparam logic [1:0]  STRAP_SETTLE    = 2'h2;
endpackage
`default_nettype wire

//--- lpb_word_if.sv
// lpb_word_if: received 48-bit words from the link receiver to the
// DMA channel and register port. take is driven by the top module.
`timescale 1ns/1ns
`default_nettype none
interface lpb_word_if;
    logic [47:0] word;
    logic        valid;
    logic        backlog;
    logic        take;
    modport rx   (output word, output valid, output backlog, input take);
    modport sink (input word, input valid, input backlog, input take);
endinterface
`default_nettype wire

//--- lpb_link_rx.sv
// lpb_link_rx: samples the link clock and nibbles, builds words, one-word buffer.
// assumes link clock no faster than half core_clk after sampling.
`timescale 1ns/1ns
`default_nettype none
module lpb_link_rx #(
    parameter int NIBBLES = lpb_pkg::NIBBLES
) (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       link_clk_pin,
    input  wire logic [3:0] link_data_pin,
    input  wire logic       enable,
    output var  logic       link_ack,
    lpb_word_if.rx          word_if
);
    localparam logic [3:0] LAST = 4'(NIBBLES - 1);
    logic [2:0]  clk_sync;
    logic [3:0]  data_s1;
    logic [3:0]  data_s2;
    logic [47:0] shreg;
    logic [3:0]  ncnt;
    logic        rise;

    // link clock comes from the master and is sampled here
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_sync <= 3'h0;
            data_s1  <= 4'h0;
            data_s2  <= 4'h0;
        end else begin
            clk_sync <= {clk_sync[1:0], link_clk_pin};
            data_s1  <= link_data_pin;
            data_s2  <= data_s1;
        end
    end
    assign rise = clk_sync[1] & ~clk_sync[2];

    // first nibble ends in the top bits
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            shreg           <= 48'h0;
            ncnt            <= 4'h0;
            word_if.backlog <= 1'b0;
        end else if (rise && enable && !word_if.backlog) begin
            shreg <= {shreg[43:0], data_s2};
            if (ncnt == LAST) begin
                ncnt            <= 4'h0;
                word_if.backlog <= 1'b1;
            end else begin
                ncnt <= ncnt + 4'h1;
            end
        end else if (word_if.backlog && (!word_if.valid || word_if.take)) begin
            word_if.backlog <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            word_if.word  <= 48'h0;
            word_if.valid <= 1'b0;
            link_ack      <= 1'b0;
        end else begin
            if (word_if.backlog && (!word_if.valid || word_if.take)) begin
                word_if.word  <= shreg;
                word_if.valid <= 1'b1;
            end else if (word_if.take) begin
                word_if.valid <= 1'b0;
            end
            // full buffer withdraws acknowledge instead of dropping data
            link_ack <= enable & ~(word_if.valid & ~word_if.take);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    AST_MSB_FIRST: assert property (
        rise && enable && !word_if.backlog && ncnt == LAST
        |=> word_if.backlog && shreg[3:0] == $past(data_s2)
            && shreg[47:4] == $past(shreg[43:0]))
        else $error("word not closed after twelfth nibble");
    AST_HOLD_OFF: assert property (
        word_if.valid && !word_if.take |=> !link_ack)
        else $error("acknowledge left high with buffer full");
endmodule
`default_nettype wire

//--- lpb_dma_ch.sv
// lpb_dma_ch: receive DMA channel moving buffer words to memory.
// assumes index, modifier and count are loaded by the register port.
`timescale 1ns/1ns
`default_nettype none
module lpb_dma_ch (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        enable,
    input  wire logic        ld_index,
    input  wire logic        ld_mod,
    input  wire logic        ld_count,
    input  wire logic [31:0] ld_value,
    input  wire logic        preset,
    lpb_word_if.sink         word_if,
    output var  logic        take,
    output var  logic [31:0] index,
    output var  logic [15:0] modif,
    output var  logic [15:0] count,
    output var  logic        mem_wr,
    output var  logic [31:0] mem_addr,
    output var  logic [47:0] mem_wdata,
    output var  logic        done
);
    // no software step between words
    assign take = enable && count != 16'h0 && word_if.valid;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            index <= 32'h0;
            modif <= 16'h0;
            count <= 16'h0;
        end else if (preset) begin
            // boot block: 256 words from the base, no software step
            index <= lpb_pkg::DMA_INDEX_RST;
            modif <= lpb_pkg::DMA_MOD_RST;
            count <= lpb_pkg::DMA_COUNT_RST;
        end else begin
            if (ld_index) index <= ld_value;
            else if (take) index <= index + {16'h0, modif};
            if (ld_mod) modif <= ld_value[15:0];
            if (ld_count) count <= ld_value[15:0];
            else if (take) count <= count - 16'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_wr    <= 1'b0;
            mem_addr  <= 32'h0;
            mem_wdata <= 48'h0;
            done      <= 1'b0;
        end else begin
            mem_wr <= take;
            if (take) begin
                mem_addr  <= index;
                mem_wdata <= word_if.word;
            end
            done <= take && count == 16'h1 && !ld_count;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    AST_DMA_STORE: assert property (
        take |=> mem_wr && mem_addr == $past(index) && mem_wdata == $past(word_if.word))
        else $error("buffer word not stored at index");
    AST_DMA_STEP: assert property (
        take && !ld_index && !ld_count && !preset
        |=> index == $past(index) + {16'h0, $past(modif)} && count == $past(count) - 16'h1)
        else $error("index or count did not step");
endmodule
`default_nettype wire

//--- lpb_boot_top.sv
// lpb_boot_top: link boot receive logic with control, interrupt latch/mask,
// core mask and channel 8 registers on a plain register port.
// assumes strap, link clock and link data arrive asynchronously as pins.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module lpb_boot_top (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        boot_link_sel,
    input  wire logic        link_clk_pin,
    input  wire logic [3:0]  link_data_pin,
    output var  logic        link_ack,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [31:0] reg_rdata,
    output var  logic        mem_wr,
    output var  logic [31:0] mem_addr,
    output var  logic [47:0] mem_wdata,
    output var  logic        core_idle,
    output var  logic        lb0_irq,
    output var  logic [31:0] irq_vector,
    output var  logic        reset_idle_skip
);
    lpb_word_if word_if ();

    logic        strap_s1;
    logic        strap_s2;
    logic [1:0]  strap_cnt;
    logic        strap_cap;
    logic        link_boot;
    logic [31:0] link_control_reg;
    logic [31:0] lirptl;
    logic [31:0] next_lirptl;
    logic [31:0] imask;
    logic [31:0] buf0_dma_chain_pointer;
    logic [31:0] buf0_dma_general_pointer;
    logic [31:0] buf0_dma_index;
    logic [15:0] buf0_dma_modifier;
    logic [15:0] buf0_dma_count;
    logic        dma_take;
    logic        dma_done;
    logic        dma_en;
    logic        sw_pop;
    logic        fire;
    logic        ld_index;
    logic        ld_mod;
    logic        ld_count;
    logic [31:0] next_rdata;

    function automatic logic hit(input logic strobe, input logic [7:0] addr,
                                 input logic [7:0] ofs);
        hit = strobe && addr == ofs;
    endfunction

    // strap sampled once the synchroniser has settled after release
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_s1  <= 1'b0;
            strap_s2  <= 1'b0;
            strap_cnt <= 2'h0;
        end else begin
            strap_s1 <= boot_link_sel;
            strap_s2 <= strap_s1;
            if (strap_cnt != 2'h3) strap_cnt <= strap_cnt + 2'h1;
        end
    end
    assign strap_cap = strap_cnt == lpb_pkg::STRAP_SETTLE;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) link_boot <= 1'b0;
        else if (strap_cap) link_boot <= strap_s2;
    end

    // link control register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_control_reg <= 32'h0;
        end else if (strap_cap) begin
            link_control_reg <= strap_s2 ? lpb_pkg::CTRL_BOOT : 32'h0;
        end else if (hit(reg_wr, reg_addr, lpb_pkg::OFS_CTRL)) begin
            // boot keeps enables at one and width at zero
            if (link_boot)
                link_control_reg <= (reg_wdata | lpb_pkg::CTRL_HOLD_ONE)
                                    & ~lpb_pkg::CTRL_HOLD_ZERO;
            else
                link_control_reg <= reg_wdata;
        end
        // the end of the first DMA leaves this register alone
    end

    // interrupt latch and mask; a completion wins over a clearing write
    always_comb begin
        next_lirptl = lirptl;
        if (hit(reg_wr, reg_addr, lpb_pkg::OFS_LIRPTL)) next_lirptl = reg_wdata;
        if (fire) next_lirptl[lpb_pkg::BIT_LB0_LATCH] = 1'b0;
        if (dma_done) next_lirptl[lpb_pkg::BIT_LB0_LATCH] = 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lirptl <= 32'h0;
            imask  <= 32'h0;
        end else if (strap_cap) begin
            lirptl <= strap_s2 ? lpb_pkg::LIRPTL_BOOT : 32'h0;
            imask  <= strap_s2 ? lpb_pkg::IMASK_BOOT : 32'h0;
        end else begin
            lirptl <= next_lirptl;
            if (hit(reg_wr, reg_addr, lpb_pkg::OFS_IMASK)) imask <= reg_wdata;
        end
    end

    // a cleared mask bit keeps the latched event from being served
    assign fire = lirptl[lpb_pkg::BIT_LB0_LATCH] && lirptl[lpb_pkg::BIT_LB0_MASK]
                  && imask[lpb_pkg::BIT_IMASK_LINK];

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lb0_irq         <= 1'b0;
            irq_vector      <= 32'h0;
            core_idle       <= 1'b0;
            reset_idle_skip <= 1'b0;
        end else begin
            lb0_irq <= fire;
            if (fire) irq_vector <= lpb_pkg::VECTOR_BASE + lpb_pkg::VECTOR_LB0_OFS;
            // core waits from boot until the first block is
            if (strap_cap) core_idle <= strap_s2;
            else if (fire) core_idle <= 1'b0;
            // return to the vector area resumes past the idle slot
            if (strap_cap) reset_idle_skip <= 1'b0;
            else if (fire) reset_idle_skip <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            buf0_dma_chain_pointer   <= 32'h0;
            buf0_dma_general_pointer <= 32'h0;
        end else begin
            if (hit(reg_wr, reg_addr, lpb_pkg::OFS_DMA_CHAIN))
                buf0_dma_chain_pointer <= reg_wdata;
            if (hit(reg_wr, reg_addr, lpb_pkg::OFS_DMA_GENERAL))
                buf0_dma_general_pointer <= reg_wdata;
        end
    end

    // channel 8 preset at boot, reprogrammable for the final block
    assign ld_index = hit(reg_wr, reg_addr, lpb_pkg::OFS_DMA_INDEX);
    assign ld_mod   = hit(reg_wr, reg_addr, lpb_pkg::OFS_DMA_MOD);
    assign ld_count = hit(reg_wr, reg_addr, lpb_pkg::OFS_DMA_COUNT);

    assign dma_en = link_boot || link_control_reg[lpb_pkg::BIT_DMA_EN];
    // software draws words one at a time, so a zero fill reads none
    assign sw_pop = hit(reg_rd, reg_addr, lpb_pkg::OFS_RX_HIGH) && !dma_take
                    && word_if.valid;
    assign word_if.take = dma_take || sw_pop;

    lpb_link_rx u_rx (
        .core_clk      (core_clk),
        .rst_b         (rst_b),
        .link_clk_pin  (link_clk_pin),
        .link_data_pin (link_data_pin),
        .enable        (link_control_reg[lpb_pkg::BIT_PORT_EN]),
        .link_ack      (link_ack),
        .word_if       (word_if)
    );

    lpb_dma_ch u_dma (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .enable    (dma_en),
        .ld_index  (ld_index),
        .ld_mod    (ld_mod),
        .ld_count  (ld_count),
        .ld_value  (reg_wdata),
        .preset    (strap_cap && strap_s2),
        .word_if   (word_if),
        .take      (dma_take),
        .index     (buf0_dma_index),
        .modif     (buf0_dma_modifier),
        .count     (buf0_dma_count),
        .mem_wr    (mem_wr),
        .mem_addr  (mem_addr),
        .mem_wdata (mem_wdata),
        .done      (dma_done)
    );

    // register read, data valid in the cycle after the strobe only
    always_comb begin
        next_rdata = 32'h0;
        case (reg_addr)
            lpb_pkg::OFS_CTRL: begin
                next_rdata = link_control_reg & ~lpb_pkg::CTRL_STAT_MASK;
                next_rdata[lpb_pkg::BIT_STAT_HIGH] = word_if.valid;
                next_rdata[lpb_pkg::BIT_STAT_LOW]  = word_if.backlog;
            end
            lpb_pkg::OFS_LIRPTL:      next_rdata = lirptl;
            lpb_pkg::OFS_IMASK:       next_rdata = imask;
            lpb_pkg::OFS_DMA_INDEX:   next_rdata = buf0_dma_index;
            lpb_pkg::OFS_DMA_MOD:     next_rdata = {16'h0, buf0_dma_modifier};
            lpb_pkg::OFS_DMA_COUNT:   next_rdata = {16'h0, buf0_dma_count};
            lpb_pkg::OFS_DMA_CHAIN:   next_rdata = buf0_dma_chain_pointer;
            lpb_pkg::OFS_DMA_GENERAL: next_rdata = buf0_dma_general_pointer;
            lpb_pkg::OFS_RX_LOW:      next_rdata = word_if.word[31:0];
            lpb_pkg::OFS_RX_HIGH:     next_rdata = {16'h0, word_if.word[47:32]};
            lpb_pkg::OFS_BOOT_STAT:   next_rdata = {29'h0, reset_idle_skip, link_boot,
                                                    core_idle};
            default:                  next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) reg_rdata <= 32'h0;
        else reg_rdata <= reg_rd ? next_rdata : 32'h0;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    AST_BOOT_MASKS: assert property (
        strap_cap && strap_s2
        |=> lirptl == 32'h0001_0000 && imask == 32'h0000_4003)
        else $error("boot masks not loaded");
    AST_BOOT_CTRL: assert property (
        strap_cap && strap_s2 |=> link_control_reg == 32'h0020_0011)
        else $error("link control not forced at boot");
    AST_HELD_BITS: assert property (
        link_boot && reg_wr && reg_addr == lpb_pkg::OFS_CTRL && !strap_cap
        |=> link_control_reg[0] && link_control_reg[1] && link_control_reg[4]
            && !link_control_reg[9])
        else $error("held control bit changed by write");
    AST_DONE_IRQ: assert property (
        dma_done && lirptl[16] && imask[14] && !reg_wr && core_idle
        |-> ##2 lb0_irq && !core_idle)
        else $error("count zero did not raise interrupt");
    AST_VECTOR: assert property (
        lb0_irq |-> irq_vector == 32'h0004_0038)
        else $error("wrong interrupt vector");
    AST_MASKED: assert property (
        !lirptl[16] |=> !lb0_irq)
        else $error("masked interrupt served");
    AST_STATUS_HIGH: assert property (
        reg_rd && reg_addr == lpb_pkg::OFS_CTRL |=> reg_rdata[27] == $past(word_if.valid))
        else $error("buffer status bit wrong");
    AST_IDLE_SKIP: assert property (
        lb0_irq |-> reset_idle_skip ##1 reset_idle_skip [*2])
        else $error("reset idle not marked implicit");
    AST_CTRL_KEPT: assert property (
        dma_done && !reg_wr |=> $stable(link_control_reg))
        else $error("link control changed at DMA end");

    COV_BOOT_DONE: cover property (dma_done ##[1:4] lb0_irq);
    COV_FULL_HOLD: cover property (word_if.valid && word_if.backlog && !link_ack);
    COV_SW_POP:    cover property (sw_pop ##1 reg_rdata != 32'h0);
endmodule
`default_nettype wire

//--- lpb_link_master.sv
// lpb_link_master: behavioural booting master driving link clock and nibbles.
// assumes the receiver raises link_ack when it can take a whole word.
`timescale 1ns/1ns
`default_nettype none
module lpb_link_master (
    input  wire logic       link_ack,
    output var  logic       link_clk,
    output var  logic [3:0] link_data
);
    initial begin
        link_clk  = 1'b0;
        link_data = 4'hA;
    end
    task automatic send_word(input logic [47:0] w);
        wait (link_ack === 1'b1);
        for (int i = 11; i >= 0; i--) begin
            link_data = w[i*4 +: 4];
            #31 link_clk = 1'b1;
            #62 link_clk = 1'b0;
            #32;
        end
        // released data lines flip so a stale nibble never looks valid
        link_data = ~link_data;
        #60;
    endtask
endmodule
`default_nettype wire

//--- tb_link_port_boot_loader.sv
// tb_link_port_boot_loader: random boot image over the link, register checks.
// assumes lpb_boot_top with link boot strapped and the master model beside it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_link_port_boot_loader;
    logic core_clk, rst_b, boot_link_sel, link_clk_pin, link_ack, reg_wr, reg_rd;
    logic mem_wr, core_idle, lb0_irq, reset_idle_skip;
    logic [3:0]  link_data_pin;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, mem_addr, irq_vector, d, lo, exp_addr;
    logic [47:0] mem_wdata, w, exp_w;
    logic [47:0] exp_q [$];
    logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'hFC};
    logic [31:0] re [7] = '{lpb_pkg::CTRL_BOOT, lpb_pkg::LIRPTL_BOOT, lpb_pkg::IMASK_BOOT,
        lpb_pkg::DMA_INDEX_RST, {16'h0000, lpb_pkg::DMA_MOD_RST},
        {16'h0000, lpb_pkg::DMA_COUNT_RST}, 32'h0000_0000};
    integer seed = 32'h98EFC3E1;
    int miscompares = 0;
    int total_checks = 0;
    int irq_cnt = 0;
    lpb_boot_top dut (.core_clk(core_clk), .rst_b(rst_b), .boot_link_sel(boot_link_sel),
        .link_clk_pin(link_clk_pin), .link_data_pin(link_data_pin), .link_ack(link_ack),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .core_idle(core_idle), .lb0_irq(lb0_irq),
        .irq_vector(irq_vector), .reset_idle_skip(reset_idle_skip));
    lpb_link_master lm (.link_ack(link_ack), .link_clk(link_clk_pin),
        .link_data(link_data_pin));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        v = reg_rdata;
    endtask
    // one word over the link, drawn by software through the buffer registers
    task automatic xfer(input logic [47:0] v);
        logic [31:0] s;
        lm.send_word(v);
        repeat (10) @(posedge core_clk);
        `CHK(link_ack, 1'b0)
        reg_read(8'h00, s);
        `CHK(s[27], 1'b1)
        reg_read(8'h20, lo);
        reg_read(8'h24, s);
        `CHK({s[15:0], lo}, v)
        reg_read(8'h00, s);
        `CHK(s[27], 1'b0)
    endtask
    task automatic send_rand(input int n);
        for (int i = 0; i < n; i++) begin
            w = 48'({$random(seed), $random(seed)});
            if (i == 0) w = 48'hFFFF_FFFF_FFFF;
            if (i == 1) w = 48'h0000_0000_0000;
            exp_q.push_back(w);
            lm.send_word(w);
        end
        repeat (20) @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        if (mem_wr === 1'b1) begin
            exp_w = exp_q.pop_front();
            `CHK({mem_addr, mem_wdata}, {exp_addr, exp_w})
            exp_addr <= exp_addr + 32'h1;
        end
        if (lb0_irq === 1'b1) irq_cnt++;
    end
    initial begin
        #700_000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        rst_b = 1'b0;
        boot_link_sel = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        exp_addr = 32'h0004_0000;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge core_clk);
        for (int i = 0; i < 7; i++) begin
            reg_read(ra[i], d);
            `CHK(d, re[i])
        end
        `CHK(core_idle, 1'b1)
        reg_write(8'h00, 32'h0);
        reg_read(8'h00, d);
        `CHK(d, lpb_pkg::CTRL_HOLD_ONE)
        reg_write(8'h00, lpb_pkg::CTRL_BOOT);
        send_rand(255);
        `CHK({core_idle, irq_cnt}, {1'b1, 32'd0})
        send_rand(1);
        `CHK({core_idle, irq_cnt, reset_idle_skip}, {1'b0, 32'd1, 1'b1})
        `CHK(irq_vector, lpb_pkg::VECTOR_BASE + lpb_pkg::VECTOR_LB0_OFS)
        reg_read(8'h14, d);
        `CHK(d, 32'h0)
        reg_read(8'h00, d);
        `CHK(d, lpb_pkg::CTRL_BOOT | lpb_pkg::CTRL_HOLD_ONE)
        // load records drawn by software: init, zero fill, final
        xfer(48'h4 + 48'($unsigned($random(seed)) % 3));
        xfer({16'h0002, 32'h0005_0000});
        for (int i = 0; i < 2; i++) begin
            xfer(48'({$random(seed), $random(seed)}));
        end
        xfer(48'h1 + 48'($unsigned($random(seed)) % 3));
        xfer({16'h0010, 32'h0005_0100});
        xfer(48'h0);
        xfer(48'({$random(seed), $random(seed)}));
        reg_write(8'h04, 32'h0);
        reg_write(8'h0C, 32'h0004_0000);
        reg_write(8'h10, 32'h1);
        exp_addr = 32'h0004_0000;
        reg_write(8'h14, 32'h4);
        send_rand(4);
        `CHK({irq_cnt, exp_addr}, {32'd1, 32'h0004_0004})
        reg_read(8'h04, d);
        `CHK(d, 32'h1)
        tally_and_finish();
    end
endmodule
`default_nettype wire
